// ---- pot_consts.vh ----
`ifndef POT_CONSTS_VH
`define POT_CONSTS_VH

// Instruction opcodes, upper nibble of the instruction byte.
`define OP_RD_WIPER   4'h9
`define OP_WR_WIPER   4'hA
`define OP_RD_STORE   4'hB
`define OP_WR_STORE   4'hC
`define OP_LOAD_ONE   4'hD
`define OP_SAVE_ONE   4'hE
`define OP_LOAD_GANG  4'h1
`define OP_SAVE_GANG  4'h8
`define OP_STEP       4'h2

// Field positions inside the address and instruction bytes.
`define TYPE_HI       7
`define TYPE_LO       4
`define ADDR_HI       3
`define ADDR_LO       0
`define OP_HI         7
`define OP_LO         4
`define SEL_HI        3
`define SEL_LO        2
`define POT_HI        1
`define POT_LO        0

// Serial framing.
`define BITS_PER_BYTE 4'h8
`define ACK_DONE_CNT  4'h9
`define CNT_ZERO      4'h0
`define CNT_ONE       4'h1

// Reset values.
`define WIPER_RST     8'h00
`define SYNC_RST      6'h30
`define BYTE_ZERO     8'h00

// Wiper end stops.
`define TAP_MIN       8'h00
`define TAP_MAX       8'hFF

// Non-volatile programming time.
`define NV_WRITE_MS   10
`define CLK_KHZ       25000

`endif

// ---- setting_store.v ----
`timescale 1ns/1ps
`default_nettype none

module setting_store #(
  parameter AW = 3,
  parameter DW = 8
) (
  input  wire          clk_sys_i,
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [DW-1:0] wdata_i,
  input  wire [AW-1:0] raddr_i,
  output reg  [DW-1:0] rdata_o
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Contents are non-volatile by intent, so there is no reset here.
  always @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule

`default_nettype wire

// ---- pot_cmd_decoder.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pot_consts.vh"

module pot_cmd_decoder #(
  // Device-type field value is arbitrary.
  parameter [3:0] DEV_TYPE       = 4'h9,
  parameter       NV_BUSY_CYCLES = `NV_WRITE_MS * `CLK_KHZ
) (
  input  wire       clk_sys_i,
  input  wire       rst_i,
  input  wire       scl_i,
  input  wire       sda_i,
  input  wire [3:0] addr_pins_i,
  output reg        sda_o,
  output reg        sda_oe_o,
  output reg  [7:0] wiper0_o,
  output reg  [7:0] wiper1_o,
  output reg        nv_busy_o
);

  localparam [2:0] S_IDLE  = 3'd0;
  localparam [2:0] S_ADDR  = 3'd1;
  localparam [2:0] S_INSTR = 3'd2;
  localparam [2:0] S_WDATA = 3'd3;
  localparam [2:0] S_RDATA = 3'd4;
  localparam [2:0] S_STEP  = 3'd5;
  localparam [2:0] S_WAIT  = 3'd6;

  localparam [1:0] E_IDLE  = 2'd0;
  localparam [1:0] E_SAVE2 = 2'd1;
  localparam [1:0] E_LOADG = 2'd2;
  localparam [1:0] E_LOAD1 = 2'd3;

  localparam [31:0] BUSY_MAX = NV_BUSY_CYCLES;

  function [7:0] step_tap;
    input [7:0] tap;
    input       up;
    begin
      if (up) begin
        step_tap = (tap == `TAP_MAX) ? `TAP_MAX : tap + 8'h01;
      end else begin
        step_tap = (tap == `TAP_MIN) ? `TAP_MIN : tap - 8'h01;
      end
    end
  endfunction

  function [2:0] store_addr;
    input       pot;
    input [1:0] sel;
    begin
      store_addr = {pot, sel};
    end
  endfunction

  function op_known;
    input [3:0] op;
    begin
      case (op)
        `OP_RD_WIPER, `OP_WR_WIPER, `OP_RD_STORE, `OP_WR_STORE, `OP_LOAD_ONE,
        `OP_SAVE_ONE, `OP_LOAD_GANG, `OP_SAVE_GANG, `OP_STEP: op_known = 1'b1;
        default: op_known = 1'b0;
      endcase
    end
  endfunction

  reg  [5:0]  sync1_ff;
  reg  [5:0]  sync2_ff;
  reg  [5:0]  sync3_ff;
  reg  [5:0]  lvl_ff;
  reg         scl_prev_ff;
  reg         sda_prev_ff;
  reg  [2:0]  state_ff;
  reg  [3:0]  cnt_ff;
  reg  [7:0]  shift_ff;
  reg  [7:0]  tx_ff;
  reg  [3:0]  op_ff;
  reg  [1:0]  sel_ff;
  reg         pot_ff;
  reg  [7:0]  data_ff;
  reg         cmd_ok_ff;
  reg  [1:0]  xstate_ff;
  reg         xpot_ff;
  reg  [31:0] busy_cnt_ff;

  wire [5:0] nxt_lvl = (~(sync2_ff ^ sync3_ff) & sync2_ff) | ((sync2_ff ^ sync3_ff) & lvl_ff);
  wire       scl     = lvl_ff[5];
  wire       sda     = lvl_ff[4];
  wire [3:0] addr    = lvl_ff[3:0];
  wire       scl_rise = scl & ~scl_prev_ff;
  wire       scl_fall = ~scl & scl_prev_ff;
  wire       start_det = scl & scl_prev_ff & ~sda & sda_prev_ff;
  wire       stop_det  = scl & scl_prev_ff & sda & ~sda_prev_ff;
  wire [3:0] in_op   = shift_ff[`OP_HI:`OP_LO];
  wire       gang_op = (op_ff == `OP_LOAD_GANG) || (op_ff == `OP_SAVE_GANG);
  wire       exec    = stop_det && cmd_ok_ff;
  wire [7:0] rdata;

  reg        mem_we;
  reg  [2:0] mem_waddr;
  reg  [7:0] mem_wdata;
  reg        busy_start;
  wire [2:0] mem_raddr = (xstate_ff == E_LOADG) ? store_addr(1'b1, sel_ff) :
                         store_addr(pot_ff & ~gang_op, sel_ff);

  // Pin inputs pass three stages; a change is taken once stages two and three agree.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_ff    <= `SYNC_RST;
      sync2_ff    <= `SYNC_RST;
      sync3_ff    <= `SYNC_RST;
      lvl_ff      <= `SYNC_RST;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      sync1_ff    <= {scl_i, sda_i, addr_pins_i};
      sync2_ff    <= sync1_ff;
      sync3_ff    <= sync2_ff;
      lvl_ff      <= nxt_lvl;
      scl_prev_ff <= scl;
      sda_prev_ff <= sda;
    end
  end

  // Serial slave: bit counter runs 0..8 for data bits, 9 after the acknowledge clock.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff  <= S_IDLE;
      cnt_ff    <= `CNT_ZERO;
      shift_ff  <= `BYTE_ZERO;
      tx_ff     <= `BYTE_ZERO;
      op_ff     <= 4'h0;
      sel_ff    <= 2'b00;
      pot_ff    <= 1'b0;
      data_ff   <= `BYTE_ZERO;
      cmd_ok_ff <= 1'b0;
      sda_oe_o  <= 1'b0;
      sda_o     <= 1'b0;
    end else if (start_det) begin
      state_ff  <= S_ADDR;
      cnt_ff    <= `CNT_ZERO;
      cmd_ok_ff <= 1'b0;
      sda_oe_o  <= 1'b0;
    end else if (stop_det) begin
      state_ff  <= S_IDLE;
      cmd_ok_ff <= 1'b0;
      sda_oe_o  <= 1'b0;
    end else if (scl_rise && state_ff != S_IDLE) begin
      if (cnt_ff < `ACK_DONE_CNT) begin
        cnt_ff <= cnt_ff + `CNT_ONE;
      end
      if (cnt_ff < `BITS_PER_BYTE) begin
        shift_ff <= {shift_ff[6:0], sda};
      end
    end else if (scl_fall) begin
      case (state_ff)
        S_ADDR: begin
          if (cnt_ff == `BITS_PER_BYTE) begin
            sda_oe_o <= (shift_ff[`TYPE_HI:`TYPE_LO] == DEV_TYPE) &&
                        (shift_ff[`ADDR_HI:`ADDR_LO] == addr) && !nv_busy_o;
          end else if (cnt_ff == `ACK_DONE_CNT) begin
            sda_oe_o <= 1'b0;
            cnt_ff   <= `CNT_ZERO;
            state_ff <= sda_oe_o ? S_INSTR : S_IDLE;
          end
        end
        S_INSTR: begin
          if (cnt_ff == `BITS_PER_BYTE) begin
            sda_oe_o <= op_known(in_op);
            op_ff    <= in_op;
            sel_ff   <= shift_ff[`SEL_HI:`SEL_LO];
            pot_ff   <= shift_ff[`POT_LO];
          end else if (cnt_ff == `ACK_DONE_CNT) begin
            sda_oe_o <= 1'b0;
            cnt_ff   <= `CNT_ZERO;
            if (!sda_oe_o) begin
              state_ff <= S_IDLE;
            end else begin
              case (op_ff)
                `OP_WR_WIPER, `OP_WR_STORE: state_ff <= S_WDATA;
                `OP_RD_STORE, `OP_RD_WIPER: begin
                  state_ff <= S_RDATA;
                  tx_ff    <= (op_ff == `OP_RD_STORE) ? rdata :
                              (pot_ff ? wiper1_o : wiper0_o);
                  sda_oe_o <= (op_ff == `OP_RD_STORE) ? ~rdata[7] :
                              ~(pot_ff ? wiper1_o[7] : wiper0_o[7]);
                end
                `OP_STEP: state_ff <= S_STEP;
                default: begin
                  state_ff  <= S_WAIT;
                  cmd_ok_ff <= 1'b1;
                end
              endcase
            end
          end
        end
        S_WDATA: begin
          if (cnt_ff == `BITS_PER_BYTE) begin
            sda_oe_o  <= 1'b1;
            data_ff   <= shift_ff;
            cmd_ok_ff <= 1'b1;
          end else if (cnt_ff == `ACK_DONE_CNT) begin
            sda_oe_o <= 1'b0;
            cnt_ff   <= `CNT_ZERO;
            state_ff <= S_WAIT;
          end
        end
        S_RDATA: begin
          if (cnt_ff < `BITS_PER_BYTE) begin
            sda_oe_o <= ~tx_ff[6];
            tx_ff    <= {tx_ff[6:0], 1'b0};
          end else if (cnt_ff == `BITS_PER_BYTE) begin
            sda_oe_o <= 1'b0;
          end else begin
            cnt_ff   <= `CNT_ZERO;
            state_ff <= S_WAIT;
          end
        end
        S_WAIT: begin
          sda_oe_o <= 1'b0;
        end
        S_STEP: begin
          sda_oe_o <= 1'b0;
        end
        default: begin
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

  always @* begin
    mem_we     = 1'b0;
    mem_waddr  = store_addr(pot_ff, sel_ff);
    mem_wdata  = data_ff;
    busy_start = 1'b0;
    if (exec) begin
      case (op_ff)
        `OP_WR_STORE: begin
          mem_we     = 1'b1;
          busy_start = 1'b1;
        end
        `OP_SAVE_ONE: begin
          mem_we     = 1'b1;
          mem_wdata  = pot_ff ? wiper1_o : wiper0_o;
          busy_start = 1'b1;
        end
        `OP_SAVE_GANG: begin
          mem_we    = 1'b1;
          mem_waddr = store_addr(1'b0, sel_ff);
          mem_wdata = wiper0_o;
        end
        default: mem_we = 1'b0;
      endcase
    end else if (xstate_ff == E_SAVE2) begin
      mem_we     = 1'b1;
      mem_waddr  = store_addr(1'b1, sel_ff);
      mem_wdata  = wiper1_o;
      busy_start = 1'b1;
    end
  end

  // Wipers and the post-STOP executor; copies run only once the frame is closed.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wiper0_o  <= `WIPER_RST;
      wiper1_o  <= `WIPER_RST;
      xstate_ff <= E_IDLE;
      xpot_ff   <= 1'b0;
    end else begin
      case (xstate_ff)
        E_SAVE2: xstate_ff <= E_IDLE;
        E_LOADG: begin
          wiper0_o  <= rdata;
          xpot_ff   <= 1'b1;
          xstate_ff <= E_LOAD1;
        end
        E_LOAD1: begin
          if (xpot_ff) begin
            wiper1_o <= rdata;
          end else begin
            wiper0_o <= rdata;
          end
          xstate_ff <= E_IDLE;
        end
        default: begin
          if (exec) begin
            case (op_ff)
              `OP_WR_WIPER: begin
                if (pot_ff) begin
                  wiper1_o <= data_ff;
                end else begin
                  wiper0_o <= data_ff;
                end
              end
              `OP_SAVE_GANG: xstate_ff <= E_SAVE2;
              `OP_LOAD_GANG: xstate_ff <= E_LOADG;
              `OP_LOAD_ONE: begin
                xpot_ff   <= pot_ff;
                xstate_ff <= E_LOAD1;
              end
              default: xstate_ff <= E_IDLE;
            endcase
          end else if (state_ff == S_STEP && scl_rise && !start_det && !stop_det) begin
            if (pot_ff) begin
              wiper1_o <= step_tap(wiper1_o, sda);
            end else begin
              wiper0_o <= step_tap(wiper0_o, sda);
            end
          end
        end
      endcase
    end
  end

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      busy_cnt_ff <= 32'h0;
      nv_busy_o   <= 1'b0;
    end else if (busy_start) begin
      busy_cnt_ff <= BUSY_MAX - 32'h1;
      nv_busy_o   <= 1'b1;
    end else if (busy_cnt_ff != 32'h0) begin
      busy_cnt_ff <= busy_cnt_ff - 32'h1;
    end else begin
      nv_busy_o <= 1'b0;
    end
  end

  // Two pots by four settings of eight bits.
  setting_store #(
    .AW (3),
    .DW (8)
  ) u_store (
    .clk_sys_i (clk_sys_i),
    .we_i      (mem_we),
    .waddr_i   (mem_waddr),
    .wdata_i   (mem_wdata),
    .raddr_i   (mem_raddr),
    .rdata_o   (rdata)
  );

endmodule

`default_nettype wire

// ---- dummy_end_marker_never_used.v ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- pot_cmd_decoder_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module pot_cmd_decoder_sva #(
  parameter NV_BUSY_CYCLES = 200
) (
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic [3:0] addr_pins_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic [7:0] wiper0_o,
  input wire logic [7:0] wiper1_o,
  input wire logic       nv_busy_o
);
  logic [3:0]  idle_ff;
  logic [31:0] busy_cnt_ff;
  // Counts cycles of an idle bus (saturating) and the length of each busy period.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      idle_ff     <= 4'h0;
      busy_cnt_ff <= 32'h0;
    end else begin
      idle_ff     <= !(scl_i && sda_i) ? 4'h0 : (idle_ff == 4'hF) ? idle_ff : idle_ff + 4'h1;
      busy_cnt_ff <= nv_busy_o ? busy_cnt_ff + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_drive_low; sda_o == 1'b0; endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("data output not low");
  property p_reset_vals;
    $fell(rst_i) |-> wiper0_o == 8'h00 && wiper1_o == 8'h00 && !nv_busy_o && !sda_oe_o;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("bad values after reset");
  property p_busy_len; $fell(nv_busy_o) |-> busy_cnt_ff == NV_BUSY_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy period has wrong length");
  property p_busy_hold; $rose(nv_busy_o) |=> nv_busy_o[*8]; endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped early");
  property p_busy_after_stop; $rose(nv_busy_o) |-> scl_i && sda_i; endproperty
  a_busy_after_stop: assert property (p_busy_after_stop)
    else $error("programming started inside a frame");
  property p_busy_quiet; nv_busy_o |-> !sda_oe_o; endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("line driven while busy");
  property p_idle_quiet;
    idle_ff >= 4'hC |-> $stable(wiper0_o) && $stable(wiper1_o) && !sda_oe_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("activity on an idle bus");
  property p_one_pot; !($changed(wiper0_o) && $changed(wiper1_o)); endproperty
  a_one_pot: assert property (p_one_pot)
    else $error("both wipers moved in one cycle");
  c_busy: cover property ($rose(nv_busy_o));
  c_ack: cover property ($rose(sda_oe_o));
  c_top: cover property (wiper0_o == 8'hFF);
endmodule
bind pot_cmd_decoder pot_cmd_decoder_sva #(.NV_BUSY_CYCLES(NV_BUSY_CYCLES)) u_sva (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
  .addr_pins_i(addr_pins_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .wiper0_o(wiper0_o), .wiper1_o(wiper1_o), .nv_busy_o(nv_busy_o)
);
`default_nettype wire

// ---- host_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // The device answers about five clocks after it sees SCL fall, so data moves only then.
  // SCL high is kept to two clocks so that a whole bit still fits in one link period.
  task automatic wbit(input logic b, output logic r);
    repeat (5) @(posedge clk_i);
    sda_low_o <= !b;
    @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  task automatic start();
    repeat (4) @(posedge clk_i);
    sda_low_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    repeat (2) @(posedge clk_i);
    sda_low_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sda_low_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic wbyte(input logic [7:0] dt, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) wbit(dt[i], r);
    wbit(1'b1, nak);
  endtask
  task automatic rbyte(output logic [7:0] dt);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      wbit(1'b1, r);
      dt[i] = r;
    end
    wbit(1'b1, r);
  endtask
endmodule
`default_nettype wire

// ---- dual_pot_serial_command_decoder_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dual_pot_serial_command_decoder_tb;
  localparam logic [3:0] DEV = 4'h6; // Device-type value is arbitrary.
  localparam int         NV  = 200;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [3:0]  pins      = 4'h0;
  logic        stb       = 1'b0;
  wire         scl, h_low, sda, sda_o, sda_oe, busy;
  wire  [7:0]  w0, w1;
  logic [17:0] q[$];
  logic [17:0] it;
  logic [15:0] ob;
  logic [7:0]  rd, v0, v1, d, a;
  logic        nak;
  int          seed = 12884;
  int          n_errors = 0;
  int          num_checks = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  assign sda = ~(h_low | (sda_oe & ~sda_o));
  pot_cmd_decoder #(.DEV_TYPE(DEV), .NV_BUSY_CYCLES(NV)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .addr_pins_i(pins),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .wiper0_o(w0), .wiper1_o(w1), .nv_busy_o(busy)
  );
  host_bus_model h (.clk_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .sda_low_o(h_low));
  task complete_run();
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [1:0] k, input logic [15:0] e);
    q.push_back({k, e});
    stb <= 1'b1;
    @(posedge clk_sys_i);
    stb <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task frm(input logic [7:0] ad, input logic [7:0] ins, input logic [1:0] m, input logic [7:0] dt);
    logic r;
    h.start();
    h.wbyte(ad, nak);
    h.wbyte(ins, r);
    if (m == 2'h1) h.wbyte(dt, r);
    if (m == 2'h2) h.rbyte(rd);
    if (m == 2'h3) for (int i = 7; i > 0; i--) h.wbit(dt[i], r);
    h.stop();
    repeat (12) @(posedge clk_sys_i);
  endtask
  task idle();
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk_sys_i);
  endtask
  always @(posedge clk_sys_i) begin
    if (stb) begin
      it = q.pop_front();
      ob = (it[17:16] == 2'h0) ? {w1, w0} : (it[17:16] == 2'h1) ? {8'h00, rd} : {15'h0000, nak};
      num_checks++;
      if (ob !== it[15:0]) begin
        n_errors++;
        $display("CHECK FAILED at %0t expected %h got %h", $time, it[15:0], ob);
      end
    end
  end
  initial begin
    @(posedge clk_sys_i);
    pins <= 4'($random(seed));
    repeat (7) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    a = {DEV, pins};
    v0 = 8'($random(seed));
    v1 = 8'($random(seed));
    d = 8'($random(seed));
    chk(2'h0, 16'h0000);
    frm(a, 8'hA0, 2'h1, v0);
    frm(a, 8'hA1, 2'h1, v1);
    chk(2'h0, {v1, v0});
    frm(a ^ 8'h01, 8'hA0, 2'h1, ~v0);
    chk(2'h2, 16'h0001);
    chk(2'h0, {v1, v0});
    frm(a, 8'h8C, 2'h0, 8'h00);
    chk(2'h2, 16'h0000);
    frm(a, 8'hB0, 2'h2, 8'h00);
    chk(2'h2, 16'h0001);
    idle();
    frm(a, 8'hC4, 2'h1, d);
    idle();
    frm(a, 8'hB4, 2'h2, 8'h00);
    chk(2'h1, {8'h00, d});
    frm(a, 8'hE9, 2'h0, 8'h00);
    idle();
    frm(a, 8'hB9, 2'h2, 8'h00);
    chk(2'h1, {8'h00, v1});
    frm(a, 8'hA0, 2'h1, ~v0);
    frm(a, 8'hA1, 2'h1, ~v1);
    frm(a, 8'h1C, 2'h0, 8'h00);
    chk(2'h0, {v1, v0});
    frm(a, 8'hD4, 2'h0, 8'h00);
    chk(2'h0, {v1, d});
    frm(a, 8'h91, 2'h2, 8'h00);
    chk(2'h1, {8'h00, v1});
    frm(a, 8'hA0, 2'h1, 8'hFD);
    frm(a, 8'h20, 2'h3, 8'hFF);
    frm(a, 8'hA1, 2'h1, 8'h02);
    frm(a, 8'h21, 2'h3, 8'h80);
    chk(2'h0, 16'h00FE);
    complete_run();
  end
  initial begin
    #2000000;
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
